/* File: waveform_params.svh */
// Register offsets, field positions and reset values of the waveform bus master.
`ifndef WAVEFORM_PARAMS_SVH
`define WAVEFORM_PARAMS_SVH

`define ADDR_W 8
`define OFS_CONFIG 8'h00
`define OFS_CONTROL 8'h04
`define OFS_STATUS 8'h08
`define OFS_ADDRESS 8'h0C
`define OFS_COUNT0 8'h10
`define OFS_COUNT1 8'h14
`define OFS_COUNT2 8'h18
`define OFS_COUNT3 8'h1C
`define VEC_REGION 3'h2
`define NUM_VECTORS 8
`define STEP_W 3

`define CFG_MODE_LSB 0
`define CFG_BUS16_BIT 2
`define CFG_CLK48_BIT 3
`define CFG_CLKEXT_BIT 4
`define CFG_DIROUT_BIT 5

`define CTRL_START_BIT 0
`define CTRL_ABORT_BIT 1
`define CTRL_FSEL_LSB 2

`define STS_BUSY_BIT 0
`define STS_DONE_BIT 1
`define STS_STALL_BIT 2
`define STS_STEP_LSB 8

`define CTL_IDLE_LEVEL 6'h3F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: waveform_pkg.sv */
// Types shared by the waveform bus master and its helpers.
`include "waveform_params.svh"
package waveform_pkg;
    typedef enum logic [1:0] {
        MODE_PORT = 2'b00,
        MODE_RSVD = 2'b01,
        MODE_MASTER = 2'b10,
        MODE_SLAVE = 2'b11
    } mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_THROTTLE = 2'b01,
        ST_STEP = 2'b10
    } engine_state_t;
    typedef struct packed {
        logic [6:0] reserved;
        logic branch_en;
        logic last;
        logic addr_inc;
        logic fifo_adv;
        logic [`STEP_W-1:0] target;
        logic [5:0] match;
        logic [5:0] mask;
        logic [5:0] ctl;
    } vector_t;
    typedef struct packed {
        mode_t mode;
        logic bus16;
        logic clk48;
        logic clk_ext;
        logic dir_out;
        logic [1:0] fifo_sel;
        logic [8:0] addr;
        engine_state_t state;
        logic [`STEP_W-1:0] step;
        logic done;
        logic [5:0] ctl;
        logic [15:0] data_out;
        logic [15:0] wr_data;
        logic rd_adv;
        logic wr_adv;
        vector_t [`NUM_VECTORS-1:0] vec;
    } engine_t;
    typedef struct packed {
        logic aw_held;
        logic [`ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_t;
    typedef struct packed {
        logic [31:0] count;
    } counter_t;
endpackage

/* File: waveform_axil_slave.sv */
// AXI4-Lite slave front end that turns bus beats into register strobes.
`timescale 1ns/1ps
`include "waveform_params.svh"
module waveform_axil_slave (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    output logic reg_wr,
    output logic [`ADDR_W-1:0] reg_waddr,
    output logic [31:0] reg_wdata,
    output logic [3:0] reg_wstrb,
    input wire logic reg_wr_err,
    output logic reg_rd,
    output logic [`ADDR_W-1:0] reg_raddr,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rd_err
);
    waveform_pkg::axil_t s;
    waveform_pkg::axil_t next_s;

    // Address and data are held separately so the master may offer them in either order.
    assign awready = !s.aw_held && !s.bvalid;
    assign wready = !s.w_held && !s.bvalid;
    assign arready = !s.rvalid;
    assign reg_wr = s.aw_held && s.w_held && !s.bvalid;
    assign reg_waddr = s.awaddr;
    assign reg_wdata = s.wdata;
    assign reg_wstrb = s.wstrb;
    assign reg_rd = arvalid && !s.rvalid;
    assign reg_raddr = araddr;
    assign bresp = s.bresp;
    assign bvalid = s.bvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign rvalid = s.rvalid;

    always_comb begin
        next_s = s;
        if (awvalid && awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        if (reg_wr) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = reg_wr_err ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (reg_rd) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = reg_rd_err ? 32'h00000000 : reg_rdata;
            next_s.rresp = reg_rd_err ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

/* File: transaction_counter.sv */
// Four-byte transaction counter with byte loads and a decrement strobe.
`timescale 1ns/1ps
module transaction_counter (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Software byte loads
    input wire logic [3:0] load_en,
    input wire logic [7:0] load_data,
    // Engine side
    input wire logic dec,
    output logic [31:0] count
);
    waveform_pkg::counter_t s;
    waveform_pkg::counter_t next_s;

    assign count = s.count;

    // A software load in the same cycle overrides the decrement of that byte.
    always_comb begin
        next_s = s;
        if (dec) begin
            next_s.count = s.count - 32'h00000001;
        end
        for (int i = 0; i < 4; i++) begin
            if (load_en[i]) begin
                next_s.count[i*8 +: 8] = load_data;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    a_count_decrement: assert property (@(posedge aclk) disable iff (!aresetn)
        dec && load_en == 4'h0 |=> count == $past(count) - 32'h00000001)
        else $error("transaction count did not drop by one");
endmodule

/* File: programmable_waveform_bus_master.sv */
// Programmable waveform engine that masters a parallel bus, with its AXI4-Lite registers.
// Operation
// - Data bus runs eight or sixteen bits wide.
// - Six control outputs, nine address, six ready.
// - Vector sets control levels and ready condition.
// - Vector may advance FIFO or address.
// - Ordered vector sequence forms one waveform.
// - Control outputs may change every clock.
// - Ready inputs select the branch taken.
// - Nine address lines span 512 bytes.
// - Four-byte count drives unattended long transfers.
// - Stall while FIFO would under- or overflow; checked once per waveform, not per vector.
// - Count decrements; reads show remaining transactions.
// - Two-bit field picks port, master, slave.
// - Power-on comes up in port mode.
// - Master mode drives the FIFO select lines.
// - Interface clock source and rate selectable.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "waveform_params.svh"
module programmable_waveform_bus_master (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Parallel bus
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic [5:0] control_out,
    output logic control_oe,
    output logic [8:0] waveform_address_out,
    output logic address_oe,
    input wire logic [5:0] ready_in,
    output logic [1:0] fifo_select,
    output logic fifo_select_oe,
    // Endpoint FIFO
    input wire logic [15:0] fifo_rd_data,
    input wire logic fifo_rd_valid,
    output logic fifo_rd_advance,
    output logic [15:0] fifo_wr_data,
    input wire logic fifo_wr_ready,
    output logic fifo_wr_advance,
    // Interface clock selection
    output logic interface_clock_48,
    output logic interface_clock_external
);
    waveform_pkg::engine_t s;
    waveform_pkg::engine_t next_s;
    waveform_pkg::vector_t cur;
    logic reg_wr;
    logic [`ADDR_W-1:0] reg_waddr;
    logic [31:0] reg_wdata;
    logic [3:0] reg_wstrb;
    logic reg_rd;
    logic [`ADDR_W-1:0] reg_raddr;
    logic [31:0] reg_rdata;
    logic wr_cfg;
    logic wr_ctrl;
    logic wr_status;
    logic wr_addr;
    logic wr_vec;
    logic [3:0] cnt_load;
    logic cnt_dec;
    logic [31:0] cnt_value;
    logic cond;
    logic fifo_ok;
    logic abort_now;
    logic start_now;
    logic engine_drive;

    function automatic logic [31:0] apply_strobe(input logic [31:0] old, input logic [31:0] wd,
                                                 input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_vector(input logic [`ADDR_W-1:0] a);
        return a[`ADDR_W-1:5] == `VEC_REGION;
    endfunction

    function automatic logic addr_mapped(input logic [`ADDR_W-1:0] a);
        return is_vector(a) || a == `OFS_CONFIG || a == `OFS_CONTROL || a == `OFS_STATUS
            || a == `OFS_ADDRESS || a == `OFS_COUNT0 || a == `OFS_COUNT1
            || a == `OFS_COUNT2 || a == `OFS_COUNT3;
    endfunction

    function automatic logic [31:0] config_word(input waveform_pkg::engine_t st);
        logic [31:0] r;
        r = 32'h00000000;
        r[`CFG_MODE_LSB +: 2] = st.mode;
        r[`CFG_BUS16_BIT] = st.bus16;
        r[`CFG_CLK48_BIT] = st.clk48;
        r[`CFG_CLKEXT_BIT] = st.clk_ext;
        r[`CFG_DIROUT_BIT] = st.dir_out;
        return r;
    endfunction

    function automatic logic [31:0] read_word(input logic [`ADDR_W-1:0] a,
                                              input waveform_pkg::engine_t st,
                                              input logic [31:0] cnt);
        logic [31:0] r;
        r = 32'h00000000;
        if (is_vector(a)) begin
            r = st.vec[a[`STEP_W+1:2]];
        end else begin
            case (a)
                `OFS_CONFIG: r = config_word(st);
                `OFS_CONTROL: r[`CTRL_FSEL_LSB +: 2] = st.fifo_sel;
                `OFS_STATUS: begin
                    r[`STS_BUSY_BIT] = st.state != waveform_pkg::ST_IDLE;
                    r[`STS_DONE_BIT] = st.done;
                    r[`STS_STALL_BIT] = st.state == waveform_pkg::ST_THROTTLE;
                    r[`STS_STEP_LSB +: `STEP_W] = st.step;
                end
                `OFS_ADDRESS: r[8:0] = st.addr;
                `OFS_COUNT0: r[7:0] = cnt[7:0];
                `OFS_COUNT1: r[7:0] = cnt[15:8];
                `OFS_COUNT2: r[7:0] = cnt[23:16];
                `OFS_COUNT3: r[7:0] = cnt[31:24];
                default: r = 32'h00000000;
            endcase
        end
        return r;
    endfunction

    waveform_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .reg_wr(reg_wr),
        .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata),
        .reg_wstrb(reg_wstrb),
        .reg_wr_err(!addr_mapped(reg_waddr)),
        .reg_rd(reg_rd),
        .reg_raddr(reg_raddr),
        .reg_rdata(reg_rdata),
        .reg_rd_err(!addr_mapped(reg_raddr))
    );

    // Count bytes are separate words so software can load them in any order.
    transaction_counter u_count (
        .aclk(aclk),
        .aresetn(aresetn),
        .load_en(cnt_load),
        .load_data(reg_wdata[7:0]),
        .dec(cnt_dec),
        .count(cnt_value)
    );

    assign reg_rdata = read_word(reg_raddr, s, cnt_value);
    assign wr_cfg = reg_wr && reg_waddr == `OFS_CONFIG;
    assign wr_ctrl = reg_wr && reg_waddr == `OFS_CONTROL && reg_wstrb[0];
    assign wr_status = reg_wr && reg_waddr == `OFS_STATUS && reg_wstrb[0];
    assign wr_addr = reg_wr && reg_waddr == `OFS_ADDRESS;
    assign wr_vec = reg_wr && is_vector(reg_waddr);
    assign cnt_load[0] = reg_wr && reg_waddr == `OFS_COUNT0 && reg_wstrb[0];
    assign cnt_load[1] = reg_wr && reg_waddr == `OFS_COUNT1 && reg_wstrb[0];
    assign cnt_load[2] = reg_wr && reg_waddr == `OFS_COUNT2 && reg_wstrb[0];
    assign cnt_load[3] = reg_wr && reg_waddr == `OFS_COUNT3 && reg_wstrb[0];
    assign abort_now = wr_ctrl && reg_wdata[`CTRL_ABORT_BIT];
    assign start_now = wr_ctrl && reg_wdata[`CTRL_START_BIT];

    assign cur = s.vec[s.step];
    assign cond = ((ready_in ^ cur.match) & cur.mask) == 6'h00;
    assign fifo_ok = s.dir_out ? fifo_rd_valid : fifo_wr_ready;
    assign engine_drive = s.mode == waveform_pkg::MODE_MASTER;

    assign control_out = s.ctl;
    assign control_oe = engine_drive;
    assign waveform_address_out = s.addr;
    assign address_oe = engine_drive;
    assign fifo_select = s.fifo_sel;
    assign fifo_select_oe = engine_drive;
    assign data_out = s.data_out;
    assign data_oe = engine_drive && s.dir_out;
    assign fifo_rd_advance = s.rd_adv;
    assign fifo_wr_advance = s.wr_adv;
    assign fifo_wr_data = s.wr_data;
    assign interface_clock_48 = s.clk48;
    assign interface_clock_external = s.clk_ext;

    always_comb begin
        logic [31:0] merged;
        merged = apply_strobe(config_word(s), reg_wdata, reg_wstrb);
        next_s = s;
        next_s.rd_adv = 1'b0;
        next_s.wr_adv = 1'b0;
        cnt_dec = 1'b0;
        if (wr_cfg) begin
            next_s.mode = waveform_pkg::mode_t'(merged[`CFG_MODE_LSB +: 2]);
            next_s.bus16 = merged[`CFG_BUS16_BIT];
            next_s.clk48 = merged[`CFG_CLK48_BIT];
            next_s.clk_ext = merged[`CFG_CLKEXT_BIT];
            next_s.dir_out = merged[`CFG_DIROUT_BIT];
        end
        if (wr_ctrl) begin
            next_s.fifo_sel = reg_wdata[`CTRL_FSEL_LSB +: 2];
        end
        if (wr_addr) begin
            next_s.addr = 9'(apply_strobe({23'h000000, s.addr}, reg_wdata, reg_wstrb));
        end
        if (wr_vec) begin
            next_s.vec[reg_waddr[`STEP_W+1:2]] = waveform_pkg::vector_t'(
                apply_strobe(s.vec[reg_waddr[`STEP_W+1:2]], reg_wdata, reg_wstrb));
        end
        // The clear is applied first so a completion in the same cycle survives it.
        if (wr_status && reg_wdata[`STS_DONE_BIT]) begin
            next_s.done = 1'b0;
        end
        case (s.state)
            waveform_pkg::ST_IDLE: begin
                if (start_now && engine_drive) begin
                    next_s.state = waveform_pkg::ST_THROTTLE;
                end
            end
            waveform_pkg::ST_THROTTLE: begin
                // The FIFO is checked once per waveform, before it drives any edge.
                if (fifo_ok) begin
                    next_s.state = waveform_pkg::ST_STEP;
                    next_s.step = '0;
                    next_s.ctl = s.vec[0].ctl;
                end
            end
            waveform_pkg::ST_STEP: begin
                if (cond) begin
                    if (cur.fifo_adv && s.dir_out) begin
                        next_s.data_out = s.bus16 ? fifo_rd_data
                                                  : {8'h00, fifo_rd_data[7:0]};
                        next_s.rd_adv = 1'b1;
                    end
                    if (cur.fifo_adv && !s.dir_out) begin
                        next_s.wr_data = s.bus16 ? data_in : {8'h00, data_in[7:0]};
                        next_s.wr_adv = 1'b1;
                    end
                    if (cur.addr_inc) begin
                        next_s.addr = s.addr + 9'h001;
                    end
                    if (cur.last) begin
                        cnt_dec = 1'b1;
                        next_s.ctl = `CTL_IDLE_LEVEL;
                        // A count of zero wraps, so it runs the full 2^32 transactions.
                        if (cnt_value == 32'h00000001) begin
                            next_s.state = waveform_pkg::ST_IDLE;
                            next_s.done = 1'b1;
                        end else begin
                            next_s.state = waveform_pkg::ST_THROTTLE;
                        end
                    end else begin
                        next_s.step = s.step + 3'h1;
                        next_s.ctl = s.vec[s.step + 3'h1].ctl;
                    end
                end else if (cur.branch_en) begin
                    next_s.step = cur.target;
                    next_s.ctl = s.vec[cur.target].ctl;
                end
            end
            default: next_s.state = waveform_pkg::ST_IDLE;
        endcase
        if (s.state != waveform_pkg::ST_IDLE && (abort_now || !engine_drive)) begin
            next_s.state = waveform_pkg::ST_IDLE;
            next_s.ctl = `CTL_IDLE_LEVEL;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.ctl <= `CTL_IDLE_LEVEL;
        end else begin
            s <= next_s;
        end
    end

    a_pins_released: assert property (@(posedge aclk) disable iff (!aresetn)
        s.mode != waveform_pkg::MODE_MASTER |-> !control_oe && !address_oe && !data_oe)
        else $error("pins driven outside master mode");
    a_select_driven: assert property (@(posedge aclk) disable iff (!aresetn)
        s.mode == waveform_pkg::MODE_MASTER |-> fifo_select_oe && fifo_select == s.fifo_sel)
        else $error("fifo select not driven in master mode");
    a_step_advance: assert property (@(posedge aclk) disable iff (!aresetn)
        s.state == waveform_pkg::ST_STEP && cond && !cur.last && !abort_now && !wr_cfg
        |=> s.step == $past(s.step) + 3'h1 && control_out == s.vec[s.step].ctl)
        else $error("vector did not advance with its control levels");
    a_wait_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        s.state == waveform_pkg::ST_STEP && !cond && !cur.branch_en && !abort_now && !wr_cfg
        |=> $stable(s.step) && $stable(control_out) && s.state == waveform_pkg::ST_STEP)
        else $error("vector left before its ready condition");
    a_branch_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        s.state == waveform_pkg::ST_STEP && !cond && cur.branch_en && !abort_now && !wr_cfg
        |=> s.step == $past(cur.target))
        else $error("branch target not taken");
    a_addr_step: assert property (@(posedge aclk) disable iff (!aresetn)
        s.state == waveform_pkg::ST_STEP && cond && cur.addr_inc && !wr_addr
        |=> waveform_address_out == $past(waveform_address_out) + 9'h001)
        else $error("address did not increment");
    a_throttle_stall: assert property (@(posedge aclk) disable iff (!aresetn)
        s.state == waveform_pkg::ST_THROTTLE && !fifo_ok && !abort_now && !wr_cfg
        |=> s.state == waveform_pkg::ST_THROTTLE && !fifo_rd_advance && !fifo_wr_advance)
        else $error("engine ran while the FIFO was not ready");
    a_done_final: assert property (@(posedge aclk) disable iff (!aresetn)
        s.state == waveform_pkg::ST_STEP && cond && cur.last && cnt_value == 32'h00000001
        && !abort_now && !wr_cfg
        |=> s.state == waveform_pkg::ST_IDLE && s.done && cnt_value == 32'h00000000)
        else $error("final transaction did not end in idle with done");
    a_narrow_bus: assert property (@(posedge aclk) disable iff (!aresetn)
        !s.bus16 && $rose(fifo_wr_advance) |-> fifo_wr_data[15:8] == 8'h00)
        else $error("upper byte carried on an eight-bit bus");
endmodule

/* File: ext_peripheral.sv */
// Behavioural model of the external parallel peripheral on the far side of the bus.
`timescale 1ns/1ps
module ext_peripheral #(
    parameter int LAT = 3
) (
    // Clock
    input wire logic aclk,
    // Parallel bus
    input wire logic [5:0] control_out,
    output logic [5:0] ready_in,
    output logic [15:0] data_in
);
    logic [7:0] wait_cnt = 8'h00;
    logic [15:0] pattern = 16'h1234;
    // A strobe is control line 1 pulled low; the answer comes LAT cycles later so the
    // engine really has to hold its vector while it waits.
    always @(posedge aclk) begin
        wait_cnt <= control_out[1] ? 8'h00 : wait_cnt + 8'h01;
        pattern <= ~pattern;
    end
    // Unused ready lines and the undriven data bus change every cycle on purpose.
    assign ready_in = {pattern[5:1], wait_cnt >= LAT[7:0]};
    assign data_in = pattern;
endmodule

/* File: tb.sv */
// Self-checking testbench of the waveform bus master.
`timescale 1ns/1ps
module tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, fifo_select, wresp;
    logic interface_clock_48, interface_clock_external, fifo_wr_advance, fifo_wr_ready = 0;
    logic awready, wready, bvalid, arready, rvalid, data_oe, control_oe, address_oe;
    logic fifo_select_oe, fifo_rd_advance, fifo_rd_valid = 0;
    logic [15:0] data_in, data_out, fifo_wr_data;
    logic [5:0] control_out, ready_in;
    logic [8:0] waveform_address_out;
    int bad_count = 0, n_tests = 0, pops = 0, pushes = 0;
    programmable_waveform_bus_master dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .control_out(control_out), .control_oe(control_oe),
        .waveform_address_out(waveform_address_out), .address_oe(address_oe),
        .ready_in(ready_in), .fifo_select(fifo_select), .fifo_select_oe(fifo_select_oe),
        .fifo_rd_data(16'h5A3C), .fifo_rd_valid(fifo_rd_valid),
        .fifo_rd_advance(fifo_rd_advance), .fifo_wr_data(fifo_wr_data),
        .fifo_wr_ready(fifo_wr_ready), .fifo_wr_advance(fifo_wr_advance),
        .interface_clock_48(interface_clock_48),
        .interface_clock_external(interface_clock_external));
    ext_peripheral #(.LAT(3)) peer (.aclk(aclk), .control_out(control_out),
        .ready_in(ready_in), .data_in(data_in));
    initial begin
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (fifo_rd_advance === 1'b1) pops++;
        if (fifo_wr_advance === 1'b1) pushes++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Address and data are offered together; each is dropped once its ready was seen.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, na, nw, b;
        ta = 0;
        tw = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            na = ta | awready;
            nw = tw | wready;
            @(posedge aclk);
            awvalid <= !na;
            wvalid <= !nw;
            ta = na;
            tw = nw;
        end
        bready <= 1;
        do begin
            @(negedge aclk);
            b = bvalid;
            wresp = bresp;
            @(posedge aclk);
        end while (!b);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic t;
        araddr <= a;
        arvalid <= 1;
        do begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 0;
        rready <= 1;
        do begin
            @(negedge aclk);
            t = rvalid;
            v = rdata;
            r = rresp;
            @(posedge aclk);
        end while (!t);
        rready <= 0;
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Three counted waveforms, first stalled on an empty FIFO, address wrapping at 512.
    task automatic long_transfer();
        logic [1:0] r;
        int i;
        wr(8'h00, 32'h26);
        chk({control_oe, address_oe, fifo_select_oe, data_oe}, 4'hF);
        wr(8'h40, 32'h00E0_1041);
        wr(8'h0C, 32'h1FE);
        wr(8'h10, 32'h3);
        wr(8'h04, 32'h9);
        repeat (4) @(posedge aclk);
        rd(8'h08, d, r);
        chk(d & 32'h7, 32'h5);
        chk(control_out, 6'h3F);
        chk(fifo_select, 2'h2);
        fifo_rd_valid <= 1;
        i = 0;
        do begin
            rd(8'h08, d, r);
            i++;
        end while (d[1] !== 1'b1 && i < 200);
        chk(d & 32'h7, 32'h2);
        chk(pops, 3);
        chk(waveform_address_out, 9'h001);
        chk(data_out, 16'h5A3C);
        rd(8'h10, d, r);
        chk(d, 32'h0);
        wr(8'h08, 32'h2);
        rd(8'h08, d, r);
        chk(d[1], 1'b0);
    endtask
    // Inbound word on an eight-bit bus, with a self-branch while the peer is slow.
    task automatic narrow_inbound();
        logic [1:0] r;
        int i;
        wr(8'h00, 32'h1A);
        chk({interface_clock_48, interface_clock_external, data_oe, control_oe}, 4'hD);
        wr(8'h40, 32'h0100_1041);
        wr(8'h44, 32'h00A0_0002);
        wr(8'h10, 32'h1);
        wr(8'h04, 32'h1);
        chk(wresp, 2'h0);
        repeat (2) @(posedge aclk);
        rd(8'h08, d, r);
        chk(d & 32'h7, 32'h5);
        fifo_wr_ready <= 1;
        i = 0;
        do begin
            rd(8'h08, d, r);
            i++;
        end while (d[1] !== 1'b1 && i < 200);
        chk(d & 32'h7, 32'h2);
        chk(pushes, 1);
        chk(fifo_wr_data[15:8], 8'h00);
        chk(fifo_wr_data[7:0] == 8'h34 || fifo_wr_data[7:0] == 8'hCB, 1'b1);
    endtask
    task automatic unmapped_read();
        logic [1:0] r;
        rd(8'h30, d, r);
        chk(r, 2'h2);
        wr(8'h30, 32'h1);
        chk(wresp, 2'h2);
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk(control_out, 6'h3F);
        chk({control_oe, address_oe, fifo_select_oe, data_oe}, 4'h0);
        long_transfer();
        narrow_inbound();
        unmapped_read();
        report_and_stop();
    end
    initial begin
        #2000000;
        bad_count++;
        report_and_stop();
    end
endmodule
